// File: irq_cpu_if_consts.vh
// Constants for the interrupt CPU interface control register bank.
`ifndef IRQ_CPU_IF_CONSTS_VH
`define IRQ_CPU_IF_CONSTS_VH

// Access keys are {op0[1:0], op1[2:0], crn[3:0], crm[3:0], op2[2:0]}.
`define KEY_W                 16
`define KEY_GROUP0_SPLIT      16'hc643
`define KEY_GROUP1_SPLIT      16'hc663
`define KEY_CONTROL_EL1       16'hc664
`define KEY_CONTROL_EL3       16'hf664
`define KEY_ENABLE_EL1        16'hc665
`define KEY_ENABLE_EL2        16'he64d
`define KEY_ENABLE_EL3        16'hf665
`define KEY_AP_G0_UP_FIRST    16'hc645
`define KEY_AP_G0_UP_LAST     16'hc647
`define KEY_AP_G1_UP_FIRST    16'hc649
`define KEY_AP_G1_UP_LAST     16'hc64b

// Split-point field.
`define SPLIT_LSB             0
`define SPLIT_MSB             2
`define SPLIT_W               3
`define SPLIT_MIN_SECURE      3'h2
`define SPLIT_MIN_NONSECURE   3'h3
`define SPLIT_MIN_GROUP0      3'h2

// Control view fields.
`define CTL_NDS_BIT           17
`define CTL_A3V_BIT           15
`define CTL_LOCAL_ERROR_IRQ_SUPPORT_BIT          14
`define CTL_INTID_WIDTH_FIELD_MSB        13
`define CTL_INTID_WIDTH_FIELD_LSB        11
`define CTL_PRIORITY_WIDTH_FIELD_MSB       10
`define CTL_PRIORITY_WIDTH_FIELD_LSB       8
`define CTL_PRIO_MASK_HINT_ENABLE_BIT          6
`define CTL_RM_BIT            5
`define CTL_EOI_NS_BIT        4
`define CTL_EOI_S_BIT         3
`define CTL_EOI_EL3_BIT       2
`define CTL_EOI_CUR_BIT       1
`define CTL_COMMON_SPLIT_SELECT_NS_BIT       1
`define CTL_COMMON_SPLIT_SELECT_S_BIT        0
`define CTL_COMMON_SPLIT_SELECT_CUR_BIT      0
`define INTID_WIDTH_FIELD_VALUE          3'h0
`define PRIORITY_WIDTH_FIELD_VALUE         3'h4

// Enable register fields.
`define SRE_ENABLE_BIT        3
`define SRE_DIB_BIT           2
`define SRE_DFB_BIT           1
`define SRE_SRE_BIT           0

// Exception level encoding.
`define EL_TOP                2'h3

`endif

// File: split_point_reg.v
// One priority split-point field with its implemented floor.
module split_point_reg #(
  parameter [2:0] MIN_VALUE = 3'h2
) (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire       wr_en,
  input  wire [2:0] wr_value,
  output reg  [2:0] value_q
);

  reg [2:0] value_d;

  // Values under the floor cannot be stored, so they settle at the floor.
  always @* begin
    value_d = value_q;
    if (wr_en) begin
      value_d = (wr_value < MIN_VALUE) ? MIN_VALUE : wr_value;
    end
  end

  // The field resets to its floor, the coarsest legal split it can hold.
  always @(posedge clock) begin
    if (sys_rst) begin
      value_q <= MIN_VALUE;
    end else begin
      value_q <= value_d;
    end
  end

endmodule // split_point_reg

// File: irq_cpu_if_ctrl_regs.v
// Control and identification register bank of the interrupt CPU interface.
`include "irq_cpu_if_consts.vh"

// Overview of operation
// - Group-1 split register holds three-bit split point.
// - Split floor 0x2 Secure, 0x3 Non-secure.
// - Control bit 15 reads one, ignores writes.
// - Control bit 14 reads zero.
// - Identifier width reads zero; EL1 mirrors EL3.
// - Priority width field reads 0x4.
// - Upper active-priority register accesses are undefined.
// - Mask hint writable at EL3, read-only EL1.
// - End mode selects drop-only or drop-and-deactivate.
// - Common split lets group-0 split govern both.
// - EL3 control bit 17 reads one always.
// - EL3 routing modifier bit reads zero always.
// - EL3 holds three separate end-mode bits.
// - EL3 holds separate Secure/Non-secure common-split bits.
// - IRQ bypass disable bit mirrors EL3 copy.
// - FIQ bypass disable bit mirrors EL3 copy.
// - Interface-enable bit 0 reads one always.
// - EL2 enable bit 3 reads one always.
module irq_cpu_if_ctrl_regs (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        sysreg_valid,
  input  wire        sysreg_write,
  input  wire [1:0]  sysreg_op0,
  input  wire [2:0]  sysreg_op1,
  input  wire [3:0]  sysreg_crn,
  input  wire [3:0]  sysreg_crm,
  input  wire [2:0]  sysreg_op2,
  input  wire [31:0] sysreg_wdata,
  input  wire        secure_state,
  input  wire [1:0]  current_el,
  output reg         resp_valid_q,
  output reg         resp_hit_q,
  output reg         resp_undef_q,
  output reg  [31:0] resp_rdata_q,
  output wire [2:0]  group0_preempt_split,
  output wire [2:0]  group1_preempt_split,
  output wire        eoi_drop_only,
  output wire        prio_mask_hint_enable,
  output wire        irq_bypass_disable,
  output wire        fiq_bypass_disable
);

  // Decoded access key and per-register strobes.
  wire [`KEY_W-1:0] key;
  wire              hit_g0;
  wire              hit_g1;
  wire              hit_ctl1;
  wire              hit_ctl3;
  wire              hit_sre1;
  wire              hit_sre2;
  wire              hit_sre3;
  wire              hit_ap_upper;
  wire              wr;
  wire              top_level;

  // Stored control state; everything else in the views is constant.
  reg  prio_mask_hint_enable_q;
  reg  irq_end_mode_nonsecure_low_q;
  reg  irq_end_mode_secure_low_q;
  reg  irq_end_mode_top_level_q;
  reg  common_split_nonsecure_q;
  reg  common_split_secure_q;
  reg  irq_bypass_disable_q;
  reg  fiq_bypass_disable_q;
  reg  prio_mask_hint_enable_d;
  reg  irq_end_mode_nonsecure_low_d;
  reg  irq_end_mode_secure_low_d;
  reg  irq_end_mode_top_level_d;
  reg  common_split_nonsecure_d;
  reg  common_split_secure_d;
  reg  irq_bypass_disable_d;
  reg  fiq_bypass_disable_d;

  // Split-point copies and their write strobes.
  wire [2:0] g0_split;
  wire [2:0] g1_split_s;
  wire [2:0] g1_split_ns;
  wire [2:0] g1_split_cur;
  wire       wr_g1;

  // Views of the current security state.
  wire cur_common_split;
  wire cur_end_mode;

  // Assembled read values.
  wire [31:0] ctl1_view;
  wire [31:0] ctl3_view;
  wire [31:0] sre_view;
  wire [31:0] sre2_view;
  reg  [31:0] rdata_d;
  reg         hit_d;

  assign key = {sysreg_op0, sysreg_op1, sysreg_crn, sysreg_crm, sysreg_op2};
  assign hit_g0   = (key == `KEY_GROUP0_SPLIT);
  assign hit_g1   = (key == `KEY_GROUP1_SPLIT);
  assign hit_ctl1 = (key == `KEY_CONTROL_EL1);
  assign hit_ctl3 = (key == `KEY_CONTROL_EL3);
  assign hit_sre1 = (key == `KEY_ENABLE_EL1);
  assign hit_sre2 = (key == `KEY_ENABLE_EL2);
  assign hit_sre3 = (key == `KEY_ENABLE_EL3);
  // Only five priority bits exist, so only register zero of each
  // active-priority group is backed; the three above it are undefined.
  assign hit_ap_upper =
    ((key >= `KEY_AP_G0_UP_FIRST) && (key <= `KEY_AP_G0_UP_LAST)) ||
    ((key >= `KEY_AP_G1_UP_FIRST) && (key <= `KEY_AP_G1_UP_LAST));
  // An undefined access must leave state untouched.
  assign wr        = sysreg_valid && sysreg_write && !hit_ap_upper;
  assign top_level = (current_el == `EL_TOP);

  // The EL1 view at EL3 works on the Secure common-split copy and the EL3 end-mode copy.
  assign cur_common_split = (secure_state || top_level) ?
                            common_split_secure_q : common_split_nonsecure_q;
  assign cur_end_mode = top_level ? irq_end_mode_top_level_q :
                        secure_state ? irq_end_mode_secure_low_q :
                        irq_end_mode_nonsecure_low_q;

  // Group-1 writes go to the banked copy of the current security state.
  assign wr_g1 = wr && hit_g1;

  split_point_reg #(
    .MIN_VALUE (`SPLIT_MIN_GROUP0)
  ) u_group0_split (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .wr_en    (wr && hit_g0),
    .wr_value (sysreg_wdata[`SPLIT_MSB:`SPLIT_LSB]),
    .value_q  (g0_split)
  );

  split_point_reg #(
    .MIN_VALUE (`SPLIT_MIN_SECURE)
  ) u_group1_split_secure (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .wr_en    (wr_g1 && (secure_state || top_level)),
    .wr_value (sysreg_wdata[`SPLIT_MSB:`SPLIT_LSB]),
    .value_q  (g1_split_s)
  );

  split_point_reg #(
    .MIN_VALUE (`SPLIT_MIN_NONSECURE)
  ) u_group1_split_nonsecure (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .wr_en    (wr_g1 && !secure_state && !top_level),
    .wr_value (sysreg_wdata[`SPLIT_MSB:`SPLIT_LSB]),
    .value_q  (g1_split_ns)
  );

  assign g1_split_cur = (secure_state || top_level) ? g1_split_s : g1_split_ns;

  // With common split set, the group-0 field decides preemption for both.
  assign group0_preempt_split = g0_split;
  assign group1_preempt_split = cur_common_split ? g0_split :
                                g1_split_cur;

  // Drop-only mode moves deactivation to the separate deactivate register.
  assign eoi_drop_only         = cur_end_mode;
  assign prio_mask_hint_enable = prio_mask_hint_enable_q;
  assign irq_bypass_disable    = irq_bypass_disable_q;
  assign fiq_bypass_disable    = fiq_bypass_disable_q;

  // EL1 control view: fixed feature fields plus current-state mode bits.
  assign ctl1_view = {
    16'h0000,
    1'b1,
    1'b0,
    `INTID_WIDTH_FIELD_VALUE,
    `PRIORITY_WIDTH_FIELD_VALUE,
    1'b0,
    prio_mask_hint_enable_q,
    4'h0,
    cur_end_mode,
    cur_common_split
  };

  // EL3 control view: security-disable unsupported and routing fixed.
  assign ctl3_view = {
    14'h0000,
    1'b1,
    1'b0,
    1'b1,
    1'b0,
    `INTID_WIDTH_FIELD_VALUE,
    `PRIORITY_WIDTH_FIELD_VALUE,
    1'b0,
    prio_mask_hint_enable_q,
    1'b0,
    irq_end_mode_nonsecure_low_q,
    irq_end_mode_secure_low_q,
    irq_end_mode_top_level_q,
    common_split_nonsecure_q,
    common_split_secure_q
  };

  // Enable views share one bypass-disable pair held for the EL3 copy.
  assign sre_view = {
    29'h00000000,
    irq_bypass_disable_q,
    fiq_bypass_disable_q,
    1'b1
  };
  assign sre2_view = {
    28'h0000000,
    1'b1,
    irq_bypass_disable_q,
    fiq_bypass_disable_q,
    1'b1
  };

  // Writable-bit next values; fixed and reserved bits have no storage.
  always @* begin
    prio_mask_hint_enable_d      = prio_mask_hint_enable_q;
    irq_end_mode_nonsecure_low_d = irq_end_mode_nonsecure_low_q;
    irq_end_mode_secure_low_d    = irq_end_mode_secure_low_q;
    irq_end_mode_top_level_d     = irq_end_mode_top_level_q;
    common_split_nonsecure_d     = common_split_nonsecure_q;
    common_split_secure_d        = common_split_secure_q;
    irq_bypass_disable_d         = irq_bypass_disable_q;
    fiq_bypass_disable_d         = fiq_bypass_disable_q;
    if (wr && hit_ctl3) begin
      prio_mask_hint_enable_d      = sysreg_wdata[`CTL_PRIO_MASK_HINT_ENABLE_BIT];
      irq_end_mode_nonsecure_low_d = sysreg_wdata[`CTL_EOI_NS_BIT];
      irq_end_mode_secure_low_d    = sysreg_wdata[`CTL_EOI_S_BIT];
      irq_end_mode_top_level_d     = sysreg_wdata[`CTL_EOI_EL3_BIT];
      common_split_nonsecure_d     = sysreg_wdata[`CTL_COMMON_SPLIT_SELECT_NS_BIT];
      common_split_secure_d        = sysreg_wdata[`CTL_COMMON_SPLIT_SELECT_S_BIT];
    end
    // The EL1 view writes only the copies of the current security state;
    // its hint bit is read-only and is not touched here.
    if (wr && hit_ctl1) begin
      if (top_level) begin
        irq_end_mode_top_level_d = sysreg_wdata[`CTL_EOI_CUR_BIT];
        common_split_secure_d    = sysreg_wdata[`CTL_COMMON_SPLIT_SELECT_CUR_BIT];
      end else if (secure_state) begin
        irq_end_mode_secure_low_d = sysreg_wdata[`CTL_EOI_CUR_BIT];
        common_split_secure_d     = sysreg_wdata[`CTL_COMMON_SPLIT_SELECT_CUR_BIT];
      end else begin
        irq_end_mode_nonsecure_low_d = sysreg_wdata[`CTL_EOI_CUR_BIT];
        common_split_nonsecure_d     = sysreg_wdata[`CTL_COMMON_SPLIT_SELECT_CUR_BIT];
      end
    end
    // Every enable view aliases the same bypass disables.
    if (wr && (hit_sre1 || hit_sre2 || hit_sre3)) begin
      irq_bypass_disable_d = sysreg_wdata[`SRE_DIB_BIT];
      fiq_bypass_disable_d = sysreg_wdata[`SRE_DFB_BIT];
    end
  end

  // Control state resets to drop-and-deactivate, separate splits, no hint.
  always @(posedge clock) begin
    if (sys_rst) begin
      prio_mask_hint_enable_q      <= 1'b0;
      irq_end_mode_nonsecure_low_q <= 1'b0;
      irq_end_mode_secure_low_q    <= 1'b0;
      irq_end_mode_top_level_q     <= 1'b0;
      common_split_nonsecure_q     <= 1'b0;
      common_split_secure_q        <= 1'b0;
      irq_bypass_disable_q         <= 1'b0;
      fiq_bypass_disable_q         <= 1'b0;
    end else begin
      prio_mask_hint_enable_q      <= prio_mask_hint_enable_d;
      irq_end_mode_nonsecure_low_q <= irq_end_mode_nonsecure_low_d;
      irq_end_mode_secure_low_q    <= irq_end_mode_secure_low_d;
      irq_end_mode_top_level_q     <= irq_end_mode_top_level_d;
      common_split_nonsecure_q     <= common_split_nonsecure_d;
      common_split_secure_q        <= common_split_secure_d;
      irq_bypass_disable_q         <= irq_bypass_disable_d;
      fiq_bypass_disable_q         <= fiq_bypass_disable_d;
    end
  end

  // Read mux; state is sampled before this cycle's write lands.
  always @* begin
    rdata_d = 32'h00000000;
    hit_d   = 1'b1;
    case (1'b1)
      hit_g0: begin
        rdata_d = {29'h00000000, g0_split};
      end
      hit_g1: begin
        // With common split set, the group-1 field reports the shared one.
        rdata_d = {29'h00000000,
                   cur_common_split ? g0_split : g1_split_cur};
      end
      hit_ctl1: begin
        rdata_d = ctl1_view;
      end
      hit_ctl3: begin
        rdata_d = ctl3_view;
      end
      hit_sre1: begin
        rdata_d = sre_view;
      end
      hit_sre2: begin
        rdata_d = sre2_view;
      end
      hit_sre3: begin
        rdata_d = sre2_view;
      end
      hit_ap_upper: begin
        rdata_d = 32'h00000000;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // Answer one cycle after each access; data comes from flip-flops.
  always @(posedge clock) begin
    if (sys_rst) begin
      resp_valid_q <= 1'b0;
      resp_hit_q   <= 1'b0;
      resp_undef_q <= 1'b0;
      resp_rdata_q <= 32'h00000000;
    end else begin
      resp_valid_q <= sysreg_valid;
      resp_hit_q   <= sysreg_valid && hit_d;
      resp_undef_q <= sysreg_valid && hit_ap_upper;
      if (sysreg_valid && !sysreg_write) begin
        resp_rdata_q <= rdata_d;
      end else begin
        resp_rdata_q <= 32'h00000000;
      end
    end
  end

endmodule // irq_cpu_if_ctrl_regs

// File: ctrl_regs_asserts.sv
// Concurrent checks on the interrupt CPU interface register bank ports.
`include "irq_cpu_if_consts.vh"
module ctrl_regs_checker (
  input logic        clock,
  input logic        sys_rst,
  input logic        sysreg_valid,
  input logic        sysreg_write,
  input logic [1:0]  sysreg_op0,
  input logic [2:0]  sysreg_op1,
  input logic [3:0]  sysreg_crn,
  input logic [3:0]  sysreg_crm,
  input logic [2:0]  sysreg_op2,
  input logic [31:0] sysreg_wdata,
  input logic        secure_state,
  input logic [1:0]  current_el,
  input logic        resp_valid_q,
  input logic        resp_hit_q,
  input logic        resp_undef_q,
  input logic [31:0] resp_rdata_q,
  input logic [2:0]  group0_preempt_split,
  input logic [2:0]  group1_preempt_split,
  input logic        eoi_drop_only,
  input logic        prio_mask_hint_enable,
  input logic        irq_bypass_disable,
  input logic        fiq_bypass_disable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Full access key, so each check names one register.
  wire [15:0] key = {sysreg_op0, sysreg_op1, sysreg_crn, sysreg_crm,
                     sysreg_op2};
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // A read or a write of one register, as taken at a rising edge.
  sequence rd_key(logic [15:0] k);
    sysreg_valid && !sysreg_write && key == k;
  endsequence
  sequence wr_key(logic [15:0] k);
    sysreg_valid && sysreg_write && key == k;
  endsequence

  resp_timing_a: assert property (resp_valid_q == $past(sysreg_valid))
    else $error("response pulse not one cycle after request");
  split_floor_a: assert property (group0_preempt_split >= 3'h2 &&
    group1_preempt_split >= 3'h2) else $error("split below floor");
  ctl_ident_a: assert property (
    rd_key(`KEY_CONTROL_EL1) |=> resp_rdata_q[31:8] == 24'h000084)
    else $error("control view fixed fields wrong");
  el3_fixed_a: assert property (rd_key(`KEY_CONTROL_EL3) |=>
    resp_rdata_q[31:8] == 24'h000284 && resp_rdata_q[7:5] == 3'h0 ||
    resp_rdata_q[31:8] == 24'h000284 && resp_rdata_q[7:5] == 3'h2)
    else $error("top control view fixed fields wrong");
  hint_view_a: assert property (rd_key(`KEY_CONTROL_EL1) |=>
    resp_rdata_q[6] == $past(prio_mask_hint_enable))
    else $error("hint bit not mirrored");
  hint_ro_a: assert property (wr_key(`KEY_CONTROL_EL1) |=>
    $stable(prio_mask_hint_enable)) else $error("hint bit written low");
  bypass_view_a: assert property (
    rd_key(`KEY_ENABLE_EL1) |=> resp_rdata_q == {29'h0,
    $past(irq_bypass_disable), $past(fiq_bypass_disable), 1'b1})
    else $error("low enable view wrong");
  el2_enable_a: assert property (rd_key(`KEY_ENABLE_EL2) |=>
    resp_rdata_q == {28'h0, 1'b1, $past(irq_bypass_disable),
    $past(fiq_bypass_disable), 1'b1}) else $error("enable view wrong");
  undef_zero_a: assert property (resp_undef_q |->
    resp_hit_q && resp_rdata_q == 32'h0) else $error("undefined data");
  common_split_a: assert property (
    rd_key(`KEY_CONTROL_EL1) ##1 resp_rdata_q[0] |->
    group1_preempt_split == group0_preempt_split)
    else $error("common split not applied");
endmodule // ctrl_regs_checker

bind irq_cpu_if_ctrl_regs ctrl_regs_checker u_chk (.clock, .sys_rst,
  .sysreg_valid, .sysreg_write, .sysreg_op0, .sysreg_op1, .sysreg_crn,
  .sysreg_crm, .sysreg_op2, .sysreg_wdata, .secure_state, .current_el,
  .resp_valid_q, .resp_hit_q, .resp_undef_q, .resp_rdata_q,
  .group0_preempt_split, .group1_preempt_split, .eoi_drop_only,
  .prio_mask_hint_enable, .irq_bypass_disable, .fiq_bypass_disable);

// File: core_access_model.sv
// Processor core model issuing system register accesses to the bank.
module core_access_model (
  input  logic        clock,
  output logic        sysreg_valid,
  output logic        sysreg_write,
  output logic [15:0] key,
  output logic [31:0] sysreg_wdata,
  output logic        secure_state,
  output logic [1:0]  current_el,
  input  logic        resp_hit_q,
  input  logic        resp_undef_q,
  input  logic [31:0] resp_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle from time zero; the bench waits out reset before any access.
  initial begin
    sysreg_valid = 1'b0;
    sysreg_write = 1'b0;
    key = 16'h0;
    sysreg_wdata = 32'h0;
    secure_state = 1'b0;
    current_el = 2'h1;
  end
  // One access: raised at a falling edge, taken at the rising edge, and
  // the registered answer read at the next falling edge. The idle key and
  // data show the inverse of the last value so stale data cannot pass as fresh.
  task automatic access(input logic w, input logic [15:0] k,
    input logic [31:0] d, input logic s, input logic [1:0] e,
    output logic [31:0] rd, output logic hit, output logic und);
    @(negedge clock);
    sysreg_valid = 1'b1;
    sysreg_write = w;
    key = k;
    sysreg_wdata = d;
    secure_state = s;
    current_el = e;
    @(negedge clock);
    sysreg_valid = 1'b0;
    key = ~k;
    sysreg_wdata = ~d;
    rd = resp_rdata_q;
    hit = resp_hit_q;
    und = resp_undef_q;
  endtask
endmodule // core_access_model

// File: irq_cpu_interface_ctrl_regs_tb_top.sv
// Self-checking bench for the interrupt CPU interface register bank.
`include "irq_cpu_if_consts.vh"
module irq_cpu_interface_ctrl_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sysreg_valid, sysreg_write, secure_state;
  logic [15:0] key;
  logic [31:0] sysreg_wdata, resp_rdata_q;
  logic [1:0]  current_el;
  logic        resp_valid_q, resp_hit_q, resp_undef_q, eoi_drop_only;
  logic [2:0]  group0_preempt_split, group1_preempt_split;
  logic        prio_mask_hint_enable, irq_bypass_disable;
  logic        fiq_bypass_disable;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // 100 MHz clock.
  always #5 clock = ~clock;

  irq_cpu_if_ctrl_regs u_dut (.clock, .sys_rst, .sysreg_valid,
    .sysreg_write, .sysreg_op0(key[15:14]), .sysreg_op1(key[13:11]),
    .sysreg_crn(key[10:7]), .sysreg_crm(key[6:3]), .sysreg_op2(key[2:0]),
    .sysreg_wdata, .secure_state, .current_el, .resp_valid_q, .resp_hit_q,
    .resp_undef_q, .resp_rdata_q, .group0_preempt_split,
    .group1_preempt_split, .eoi_drop_only, .prio_mask_hint_enable,
    .irq_bypass_disable, .fiq_bypass_disable);

  core_access_model u_core (.clock, .sysreg_valid, .sysreg_write, .key,
    .sysreg_wdata, .secure_state, .current_el, .resp_hit_q, .resp_undef_q,
    .resp_rdata_q);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Write access; the answer must carry no data.
  task automatic wr(input logic [15:0] k, input logic [31:0] d,
    input logic s, input logic [1:0] e);
    logic [31:0] r;
    logic h, u;
    u_core.access(1'b1, k, d, s, e, r, h, u);
    check(r, 32'h0);
  endtask

  // Read access compared with an expected word; the bank must claim it.
  task automatic rchk(input logic [15:0] k, input logic s,
    input logic [1:0] e, input logic [31:0] exp);
    logic [31:0] r;
    logic h, u;
    u_core.access(1'b0, k, 32'h0, s, e, r, h, u);
    check(r, exp);
    check({31'h0, h}, 32'h1);
  endtask

  task automatic t_reset();
    rchk(`KEY_CONTROL_EL1, 1'b0, 2'h1, 32'h00008400);
    rchk(`KEY_CONTROL_EL3, 1'b1, 2'h3, 32'h00028400);
    rchk(`KEY_ENABLE_EL1, 1'b0, 2'h1, 32'h00000001);
    rchk(`KEY_ENABLE_EL2, 1'b0, 2'h2, 32'h00000009);
    rchk(`KEY_GROUP1_SPLIT, 1'b0, 2'h1, 32'h00000003);
    rchk(`KEY_GROUP1_SPLIT, 1'b1, 2'h1, 32'h00000002);
    $display("reset values done");
  endtask

  task automatic t_split();
    wr(`KEY_GROUP1_SPLIT, 32'hfffffff8, 1'b0, 2'h1);
    rchk(`KEY_GROUP1_SPLIT, 1'b0, 2'h1, 32'h00000003);
    wr(`KEY_GROUP1_SPLIT, 32'h00000007, 1'b0, 2'h1);
    rchk(`KEY_GROUP1_SPLIT, 1'b0, 2'h1, 32'h00000007);
    check({29'h0, group1_preempt_split}, 32'h7);
    wr(`KEY_GROUP1_SPLIT, 32'h00000001, 1'b1, 2'h1);
    rchk(`KEY_GROUP1_SPLIT, 1'b1, 2'h1, 32'h00000002);
    // The group-0 field serves common split; it is left at its floor again.
    wr(`KEY_GROUP0_SPLIT, 32'h00000005, 1'b0, 2'h1);
    rchk(`KEY_GROUP0_SPLIT, 1'b0, 2'h1, 32'h00000005);
    check({29'h0, group0_preempt_split}, 32'h5);
    wr(`KEY_GROUP0_SPLIT, 32'h00000000, 1'b0, 2'h1);
    rchk(`KEY_GROUP0_SPLIT, 1'b0, 2'h1, 32'h00000002);
    $display("split point done");
  endtask

  task automatic t_control();
    wr(`KEY_CONTROL_EL3, 32'hffffffff, 1'b1, 2'h3);
    rchk(`KEY_CONTROL_EL3, 1'b1, 2'h3, 32'h0002845f);
    rchk(`KEY_CONTROL_EL1, 1'b0, 2'h1, 32'h00008443);
    check({31'h0, eoi_drop_only}, 32'h1);
    check({29'h0, group1_preempt_split}, 32'h2);
    wr(`KEY_CONTROL_EL3, 32'h00000050, 1'b1, 2'h3);
    rchk(`KEY_CONTROL_EL1, 1'b1, 2'h1, 32'h00008440);
    check({31'h0, eoi_drop_only}, 32'h0);
    rchk(`KEY_CONTROL_EL1, 1'b0, 2'h1, 32'h00008442);
    check({29'h0, group1_preempt_split}, 32'h7);
    wr(`KEY_CONTROL_EL1, 32'h00000001, 1'b0, 2'h1);
    rchk(`KEY_CONTROL_EL3, 1'b1, 2'h3, 32'h00028442);
    check({31'h0, prio_mask_hint_enable}, 32'h1);
    $display("control views done");
  endtask

  task automatic t_enable();
    wr(`KEY_ENABLE_EL3, 32'h00000004, 1'b1, 2'h3);
    rchk(`KEY_ENABLE_EL1, 1'b0, 2'h1, 32'h00000005);
    rchk(`KEY_ENABLE_EL2, 1'b0, 2'h2, 32'h0000000d);
    wr(`KEY_ENABLE_EL3, 32'h00000002, 1'b1, 2'h3);
    rchk(`KEY_ENABLE_EL1, 1'b0, 2'h1, 32'h00000003);
    check({30'h0, irq_bypass_disable, fiq_bypass_disable}, 32'h1);
    wr(`KEY_ENABLE_EL3, 32'h00000000, 1'b1, 2'h3);
    rchk(`KEY_ENABLE_EL3, 1'b1, 2'h3, 32'h00000009);
    $display("enable registers done");
  endtask

  // Upper active-priority keys of both groups, then one unmapped key.
  task automatic t_undef();
    logic [31:0] r;
    logic h, u;
    logic [15:0] ks[6] = '{16'hc645, 16'hc646, 16'hc647, 16'hc649,
                           16'hc64a, 16'hc64b};
    foreach (ks[i]) begin
      u_core.access(1'b0, ks[i], 32'h0, 1'b0, 2'h1, r, h, u);
      check({r[31:2], h, u}, 32'h3);
    end
    u_core.access(1'b0, 16'h0000, 32'h0, 1'b0, 2'h1, r, h, u);
    check({r[31:2], h, u}, 32'h0);
    $display("undefined accesses done");
  endtask

  // Cycle ceiling cuts a hang short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      wrap_up();
    end
  end

  // Reset for five cycles, released at a falling edge, then the tests.
  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    t_reset();
    t_split();
    t_control();
    t_enable();
    t_undef();
    wrap_up();
  end
endmodule // irq_cpu_interface_ctrl_regs_tb_top
